// file: pkg/field_eval_consts.vh
// constants for the field evaluation and switching output logic
`ifndef FIELD_EVAL_CONSTS_VH
`define FIELD_EVAL_CONSTS_VH
`define CLK_FREQ_HZ        200000000
`define SCAN_PERIOD_US     13000
`define SCAN_CYCLES        (`CLK_FREQ_HZ / 1000000 * `SCAN_PERIOD_US)
`define QUAL_SCANS_DEF     8'h14
`define BLANK_CM_DEF       8'h05
`define RESTART_MS_DEF     16'h03e8
`define BLINK_HALF_MS      500
`define BLINK_HALF_CYCLES  (`CLK_FREQ_HZ / 1000 * `BLINK_HALF_MS)
`define MS_CYCLES          (`CLK_FREQ_HZ / 1000)
`define ADDR_CTRL          8'h00
`define ADDR_QUAL          8'h04
`define ADDR_BLANK         8'h08
`define ADDR_RESTART       8'h0c
`define ADDR_STATUS        8'h10
`define CTRL_C_MODE_LSB    0
`define CTRL_PULSE_WARN    2
`define CTRL_SUBTRACT      3
`define CTRL_RESET_VAL     32'h00000004
`define MODE_FIELD_C       2'h0
`define MODE_SYNC_MASTER   2'h1
`define MODE_POLL_WARN     2'h2
`define MODE_POLL_ERR      2'h3
`endif

// file: logic/field_channel.v
// one field channel: scan qualification and restart hold
`timescale 1ns/1ps
`default_nettype none
module field_channel
(
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        scan_tick,
   input  wire        ms_tick,
   input  wire        hit,
   input  wire [7:0]  qual_scans,
   input  wire [15:0] restart_ms,
   output reg         occupied_q
);
   reg  [7:0]  count_q;
   reg  [15:0] hold_q;
   reg         qual_q;

   // ===============================
   // scan qualification
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         count_q    <= 8'h00;
         qual_q     <= 1'b0;
         hold_q     <= 16'h0000;
         occupied_q <= 1'b0;
      end
      else
      begin
         if (scan_tick)
         begin
            if (!hit)
               count_q <= 8'h00;
            else if (count_q < qual_scans)
               count_q <= count_q + 8'h01;
            qual_q <= hit && ({1'b0, count_q} + 9'h001 >= {1'b0, qual_scans});
         end
         // ===============================
         // restart hold after clearing
         if (qual_q)
            hold_q <= restart_ms;
         else if (ms_tick && hold_q != 16'h0000)
            hold_q <= hold_q - 16'h0001;
         occupied_q <= qual_q || (hold_q != 16'h0000);
      end
   end
endmodule // field_channel
`default_nettype wire

// file: logic/field_eval_output.v
// field evaluation and switching output logic with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "field_eval_consts.vh"
// Summary of operation
// - output switches off (low) after object present for configured consecutive scans, default twenty
// - one scan lasts 13 ms; delay is scans times period
// - objects smaller than blanking diameter, default 5 cm, are ignored
// - field one drives output one, two drives two, three drives three; with subtract bit set, field three holds outputs one and two on
// - default mode: pollution warning blinks third output at 1 Hz, 50 percent
// - pollution error switches outputs one and two off until window is cleaned; third output blinks in field/pulse mode
// - third output mode: field/pulse, sync master, steady warning, steady error
// - steady pollution modes give constant level while condition present
// - steady pollution modes override third field result on third output
// - after a field clears, its output stays low for restart delay, 1 s
// - a digital input selects which of two field sets is evaluated
module field_eval_output
(
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hsel,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        scan_done,
   input  wire        set_select,
   input  wire [2:0]  set1_hits,
   input  wire [2:0]  set2_hits,
   input  wire [7:0]  object_size_cm,
   input  wire        field_c_present,
   input  wire        poll_warn,
   input  wire        poll_err,
   input  wire        sync_pulse,
   output reg         out_a_q,
   output reg         out_b_q,
   output reg         out_c_q
);
   reg  [31:0] ctrl_q;
   reg  [7:0]  qual_q;
   reg  [7:0]  blank_q;
   reg  [15:0] restart_q;
   reg         wr_pend_q;
   reg  [7:0]  wr_addr_q;
   reg  [31:0] scan_cnt_q;
   reg  [31:0] ms_cnt_q;
   reg  [31:0] blink_cnt_q;
   reg         blink_q;
   reg         scan_tick_q;
   reg         ms_tick_q;
   reg         err_latch_q;
   reg  [2:0]  hits_d;
   reg  [2:0]  eff_d;
   reg  [1:0]  c_mode;
   reg         c_d;
   wire [2:0]  occ;
   wire        scan_tick;

   // ===============================
   // ahb-lite slave, zero wait states
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrl_q    <= `CTRL_RESET_VAL;
         qual_q    <= `QUAL_SCANS_DEF;
         blank_q   <= `BLANK_CM_DEF;
         restart_q <= `RESTART_MS_DEF;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (wr_pend_q)
         begin
            if (wr_addr_q == `ADDR_CTRL)
               ctrl_q <= {28'h0000000, hwdata[3:0]};
            else if (wr_addr_q == `ADDR_QUAL)
               qual_q <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
            else if (wr_addr_q == `ADDR_BLANK)
               blank_q <= hwdata[7:0];
            else if (wr_addr_q == `ADDR_RESTART)
               restart_q <= hwdata[15:0];
         end
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         wr_addr_q <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite)
         begin
            if (haddr[7:0] == `ADDR_CTRL)
               hrdata <= ctrl_q;
            else if (haddr[7:0] == `ADDR_QUAL)
               hrdata <= {24'h000000, qual_q};
            else if (haddr[7:0] == `ADDR_BLANK)
               hrdata <= {24'h000000, blank_q};
            else if (haddr[7:0] == `ADDR_RESTART)
               hrdata <= {16'h0000, restart_q};
            else if (haddr[7:0] == `ADDR_STATUS)
               hrdata <= {26'h0, err_latch_q, poll_warn, set_select,
                          occ};
            else
               hrdata <= 32'h00000000;
         end
      end
   end

   // ===============================
   // timebase: scan ticks, ms ticks, 1 hz blink
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         scan_cnt_q  <= 32'h00000000;
         ms_cnt_q    <= 32'h00000000;
         blink_cnt_q <= 32'h00000000;
         blink_q     <= 1'b0;
         scan_tick_q <= 1'b0;
         ms_tick_q   <= 1'b0;
      end
      else
      begin
         scan_tick_q <= (scan_cnt_q == `SCAN_CYCLES - 1);
         scan_cnt_q  <= (scan_cnt_q == `SCAN_CYCLES - 1) ? 32'h00000000
                        : scan_cnt_q + 32'h00000001;
         ms_tick_q   <= (ms_cnt_q == `MS_CYCLES - 1);
         ms_cnt_q    <= (ms_cnt_q == `MS_CYCLES - 1) ? 32'h00000000
                        : ms_cnt_q + 32'h00000001;
         if (blink_cnt_q == `BLINK_HALF_CYCLES - 1)
         begin
            blink_cnt_q <= 32'h00000000;
            blink_q     <= ~blink_q;
         end
         else
            blink_cnt_q <= blink_cnt_q + 32'h00000001;
      end
   end

   // scans are paced by the measurement core and the timer together; either tick advances a scan
   assign scan_tick = scan_done | scan_tick_q;

   // ===============================
   // field set select and blanking
   always @*
   begin
      hits_d = set_select ? set2_hits : set1_hits;
      if (object_size_cm < blank_q)
         hits_d = 3'h0;
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : chan
         field_channel u_chan
         (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .scan_tick  (scan_tick),
            .ms_tick    (ms_tick_q),
            .hit        (hits_d[g]),
            .qual_scans (qual_q),
            .restart_ms (restart_q),
            .occupied_q (occ[g])
         );
      end
   endgenerate

   // ===============================
   // output mapping
   always @*
   begin
      c_mode = ctrl_q[`CTRL_C_MODE_LSB+1:`CTRL_C_MODE_LSB];
      eff_d  = occ;
      if (ctrl_q[`CTRL_SUBTRACT])
      begin
         eff_d[0] = occ[0] & ~occ[2];
         eff_d[1] = occ[1] & ~occ[2];
      end
      c_d = ~eff_d[2];
      if (c_mode == `MODE_FIELD_C)
      begin
         if (err_latch_q)
            c_d = blink_q;
         else if (poll_warn && ctrl_q[`CTRL_PULSE_WARN])
            c_d = field_c_present ? (~eff_d[2] & blink_q) : blink_q;
      end
      else if (c_mode == `MODE_SYNC_MASTER)
         c_d = sync_pulse;
      else if (c_mode == `MODE_POLL_WARN)
         c_d = ~poll_warn;
      else
         c_d = ~poll_err;
   end

   // ===============================
   // error latch and registered outputs
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         err_latch_q <= 1'b0;
         out_a_q     <= 1'b0;
         out_b_q     <= 1'b0;
         out_c_q     <= 1'b0;
      end
      else
      begin
         if (poll_err)
            err_latch_q <= 1'b1;
         else if (!poll_warn)
            err_latch_q <= 1'b0;
         out_a_q <= err_latch_q ? 1'b0 : ~eff_d[0];
         out_b_q <= err_latch_q ? 1'b0 : ~eff_d[1];
         out_c_q <= (err_latch_q && c_mode != `MODE_POLL_ERR
                     && c_mode != `MODE_FIELD_C) ? 1'b0 : c_d;
      end
   end
endmodule // field_eval_output
`default_nettype wire

// file: tb/crane_ctrl.sv
// crane control model reading switching output one
`timescale 1ns/1ps
`default_nettype none
module crane_ctrl
(
   input  wire logic core_clk,
   input  wire logic fast,
   input  wire logic out_a_q,
   output var  logic set_select = 1'b0,
   output var  logic brake_q = 1'b0
);
   // =========================================
   // set choice and braking
   always @(posedge core_clk)
   begin
      set_select <= fast;
      brake_q <= ~out_a_q;
   end
endmodule // crane_ctrl
`default_nettype wire

// file: tb/field_eval_chk.sv
// assertion checker for the switching output logic
`timescale 1ns/1ps
`default_nettype none
module field_eval_chk
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        set_select,
   input wire logic [2:0]  set1_hits,
   input wire logic [2:0]  set2_hits,
   input wire logic        poll_err,
   input wire logic        out_a_q,
   input wire logic        out_b_q,
   input wire logic        out_c_q
);
   // =========================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_resp; hresp == 1'b0; endproperty
   a_resp: assert property (p_resp) else $error("response not okay");
   property p_rdy; hreadyout; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state seen");
   property p_rst;
      disable iff (1'b0) !rst_n |=> {out_a_q, out_b_q, out_c_q} == 3'h0 && hrdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_err; poll_err |-> ##[1:3] !(out_a_q || out_b_q); endproperty
   a_err: assert property (p_err) else $error("outputs on in error");
   property p_afall;
      $fell(out_a_q) |-> $past(set1_hits[0] | set2_hits[0], 3) || $past(poll_err, 2);
   endproperty
   a_afall: assert property (p_afall) else $error("a fell without cause");
   property p_bfall;
      $fell(out_b_q) |-> $past(set1_hits[1] | set2_hits[1], 3) || $past(poll_err, 2);
   endproperty
   a_bfall: assert property (p_bfall) else $error("b fell without cause");
   property p_rise; ($rose(out_a_q) || $rose(out_b_q)) |-> !$past(poll_err, 2); endproperty
   a_rise: assert property (p_rise) else $error("output on in error");
   property p_arise; $rose(out_a_q) |-> !$past(set_select ? set2_hits[0] : set1_hits[0], 3);
   endproperty
   a_arise: assert property (p_arise) else $error("a freed with object");
endmodule // field_eval_chk
bind field_eval_output field_eval_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .set_select(set_select),
   .set1_hits(set1_hits), .set2_hits(set2_hits), .poll_err(poll_err),
   .out_a_q(out_a_q), .out_b_q(out_b_q), .out_c_q(out_c_q));
`default_nettype wire

// file: tb/field_eval_output_tb.sv
// self-checking testbench for the switching output logic
`timescale 1ns/1ps
`default_nettype none
module field_eval_output_tb;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        scan_done = 1'b0;
   logic        fast = 1'b0;
   logic [2:0]  set1_hits = 3'h0;
   logic [2:0]  set2_hits = 3'h0;
   logic [7:0]  size = 8'h0;
   logic        poll_warn = 1'b0;
   logic        poll_err = 1'b0;
   logic        obs = 1'b0;
   logic        rd_ph = 1'b0;
   logic        field_c_present = 1'b1;
   logic        sync_pulse = 1'b0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, set_select, out_a_q, out_b_q, out_c_q;
   int          errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [31:0] exp_q[$];
   logic [31:0] addr_t[6] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h40};
   logic [31:0] rst_t[6] = '{32'h4, 32'h14, 32'h5, 32'h3e8, 32'h0, 32'h0};
   always #2.5 core_clk = ~core_clk;
   // =========================================
   // design and far side
   field_eval_output dut_u (.core_clk(core_clk), .rst_n(rst_n), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .scan_done(scan_done), .set_select(set_select), .set1_hits(set1_hits),
      .set2_hits(set2_hits), .object_size_cm(size), .field_c_present(field_c_present),
      .poll_warn(poll_warn), .poll_err(poll_err), .sync_pulse(sync_pulse),
      .out_a_q(out_a_q), .out_b_q(out_b_q), .out_c_q(out_c_q));
   crane_ctrl partner_u (.core_clk(core_clk), .fast(fast), .out_a_q(out_a_q),
      .set_select(set_select), .brake_q());
   // =========================================
   // tasks
   task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks_done++;
      if (seen !== ex)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      if (!wr)
         exp_q.push_back(d);
      @(posedge core_clk);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
   endtask
   task automatic see(input logic [2:0] e);
      exp_q.push_back({29'h0, e});
      @(posedge core_clk);
      obs <= 1'b1;
      @(posedge core_clk);
      obs <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         scan_done <= 1'b1;
         @(posedge core_clk);
         scan_done <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   // =========================================
   // monitor and timeout
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         stop_test();
      end
      if (rd_ph && hreadyout)
         cmp("hrdata", hrdata, exp_q.pop_front());
      if (obs)
         cmp("outputs", {29'h0, out_c_q, out_b_q, out_a_q}, exp_q.pop_front());
      rd_ph <= htrans[1] && !hwrite && hreadyout && rst_n;
   end
   // =========================================
   // main sequence
   initial
   begin
      void'($urandom(25));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (addr_t[i]) bus(1'b0, addr_t[i], rst_t[i]);
      bus(1'b1, 32'h4, 32'h2);
      bus(1'b1, 32'hc, 32'h0);
      bus(1'b1, 32'h40, 32'hff);
      bus(1'b0, 32'h4, 32'h2);
      bus(1'b0, 32'h40, 32'h0);
      see(3'h7);
      $display("test registers done");
      size <= 8'($urandom_range(4, 0));
      set1_hits <= 3'h1;
      tick(3);
      see(3'h7);
      size <= 8'(5 + $urandom_range(200, 0));
      tick(1);
      see(3'h7);
      tick(1);
      see(3'h6);
      set1_hits <= 3'h0;
      tick(1);
      see(3'h7);
      $display("test qualification done");
      fast <= 1'b1;
      set1_hits <= 3'h1;
      set2_hits <= 3'h2;
      tick(2);
      see(3'h5);
      set1_hits <= 3'h4;
      set2_hits <= 3'h0;
      fast <= 1'b0;
      tick(2);
      see(3'h3);
      set1_hits <= 3'h0;
      tick(1);
      $display("test field sets done");
      bus(1'b1, 32'h0, 32'h3);
      poll_err <= 1'b1;
      repeat (4) @(posedge core_clk);
      see(3'h0);
      poll_err <= 1'b0;
      repeat (4) @(posedge core_clk);
      see(3'h7);
      bus(1'b1, 32'h0, 32'h2);
      set1_hits <= 3'h4;
      tick(2);
      see(3'h7);
      poll_warn <= 1'b1;
      repeat (4) @(posedge core_clk);
      see(3'h3);
      repeat (20) @(posedge core_clk);
      see(3'h3);
      $display("test pollution done");
      poll_warn <= 1'b0;
      set1_hits <= 3'h0;
      bus(1'b1, 32'h0, 32'h4);
      tick(1);
      field_c_present <= 1'b0;
      poll_warn <= 1'b1;
      repeat (4) @(posedge core_clk);
      see(3'h3);
      poll_warn <= 1'b0;
      repeat (4) @(posedge core_clk);
      see(3'h7);
      sync_pulse <= 1'($urandom_range(1, 0));
      bus(1'b1, 32'h0, 32'h1);
      see({sync_pulse, 2'h3});
      field_c_present <= 1'b1;
      bus(1'b1, 32'h0, 32'hc);
      set1_hits <= 3'h4;
      tick(2);
      see(3'h3);
      set1_hits <= 3'h5;
      tick(2);
      see(3'h3);
      set1_hits <= 3'h1;
      tick(1);
      see(3'h6);
      set1_hits <= 3'h0;
      tick(1);
      see(3'h7);
      $display("test output modes done");
      stop_test();
   end
endmodule // field_eval_output_tb
`default_nettype wire
